// File: flash_command_host.sv
// Host controller that issues flash command sequences over the parallel bus
`timescale 1ns/1ps
module flash_command_host
  import flash_cmd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire req_type req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_data,
  output pins_type pins,
  input wire logic [DATA_W-1:0] dq_in
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_PULSE = 3'b010,
    ST_HOLD = 3'b011,
    ST_NEXT = 3'b100,
    ST_DONE = 3'b101
  } state_type;

  state_type state_q;
  req_type cur_q;
  logic [2:0] idx_q;
  logic [CNT_W-1:0] cnt_q;
  logic [DATA_W-1:0] dq_s1_q;
  logic [DATA_W-1:0] dq_s2_q;
  pins_type pins_q;
  logic [DATA_W-1:0] rsp_data_q;
  logic rsp_valid_q;

  // Bus step table for the current operation
  logic [ADDR_W-1:0] u1;
  logic [ADDR_W-1:0] u2;
  logic [ADDR_W-1:0] bank_base;
  logic [ADDR_W-1:0] step_addr;
  logic [7:0] step_code;
  logic step_read;
  logic step_raw;
  logic [2:0] step_cnt;

  assign u1 = cur_q.byte_mode ? UNLOCK1_BYTE : UNLOCK1_WORD;
  assign u2 = cur_q.byte_mode ? UNLOCK2_BYTE : UNLOCK2_WORD;
  assign bank_base = {cur_q.addr[ADDR_W-1:BANK_LSB], {BANK_LSB{1'b0}}};

  always_comb begin
    step_addr = u1;
    step_code = CODE_UNLOCK1;
    step_read = 1'b0;
    step_raw = 1'b0;
    step_cnt = 3'd1;
    case (cur_q.op)
      OP_ARRAY_READ: begin
        step_read = 1'b1;
        step_addr = cur_q.addr;
      end
      OP_RESET: step_code = CODE_RESET;
      OP_ID_READ: begin
        // Caller keeps the same bank bits on every ID read
        step_read = 1'b1;
        step_addr = cur_q.addr;
      end
      OP_SECTOR_ADD: begin
        step_addr = {cur_q.addr[ADDR_W-1:SECTOR_LSB], {SECTOR_LSB{1'b0}}};
        step_code = CODE_SECTOR_ERASE;
      end
      OP_SUSPEND: begin
        step_addr = bank_base;
        step_code = CODE_SUSPEND;
      end
      OP_RESUME: begin
        step_addr = bank_base;
        step_code = CODE_RESUME;
      end
      OP_QUERY: begin
        step_addr = cur_q.byte_mode ? QUERY_BYTE : QUERY_WORD;
        step_code = CODE_QUERY;
      end
      OP_BYPASS_PROG: begin
        step_cnt = 3'd2;
        step_code = CODE_PROG;
        if (idx_q == 3'd1) begin
          step_addr = cur_q.addr;
          step_raw = 1'b1;
        end
      end
      OP_BYPASS_EXIT: begin
        step_cnt = 3'd2;
        step_code = (idx_q == 3'd0) ? CODE_ID : CODE_BYPASS_EXIT;
      end
      default: begin
        // Unlock prefix then command, optional second unlock and final write
        step_cnt = (cur_q.op == OP_PROGRAM) ? 3'd4 :
                   (cur_q.op == OP_CHIP_ERASE || cur_q.op == OP_SECTOR_ERASE) ? 3'd6 : 3'd3;
        // Final write of program and erase comes after the command or second unlock
        if (idx_q > 3'd2 && idx_q == step_cnt - 3'd1) begin
          if (cur_q.op == OP_PROGRAM) begin
            step_addr = cur_q.addr;
            step_raw = 1'b1;
          end else if (cur_q.op == OP_CHIP_ERASE) begin
            step_addr = u1;
            step_code = CODE_CHIP_ERASE;
          end else begin
            step_addr = {cur_q.addr[ADDR_W-1:SECTOR_LSB], {SECTOR_LSB{1'b0}}};
            step_code = CODE_SECTOR_ERASE;
          end
        end else begin
          case (idx_q)
            3'd0, 3'd3: begin
              step_addr = u1;
              step_code = CODE_UNLOCK1;
            end
            3'd1, 3'd4: begin
              step_addr = u2;
              step_code = CODE_UNLOCK2;
            end
            default: begin
              step_addr = (cur_q.op == OP_ID_ENTER || cur_q.op == OP_BYPASS_ENTER) ?
                          (bank_base | u1) : u1;
              step_code = (cur_q.op == OP_ID_ENTER) ? CODE_ID :
                          (cur_q.op == OP_BYPASS_ENTER) ? CODE_BYPASS :
                          (cur_q.op == OP_PROGRAM) ? CODE_PROG : CODE_ERASE_SETUP;
            end
          endcase
        end
      end
    endcase
  end

  // Command cycles drive zero on the upper byte; program data goes whole
  logic [DATA_W-1:0] step_data;
  assign step_data = step_raw ? cur_q.data : {8'h00, step_code};
  logic last_step;
  assign last_step = (idx_q == step_cnt - 3'd1);
  logic cnt_done;
  assign cnt_done = (cnt_q == '0);

  // Read data synchroniser
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dq_s1_q <= '0;
      dq_s2_q <= '0;
    end else begin
      dq_s1_q <= dq_in;
      dq_s2_q <= dq_s1_q;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cur_q <= '0;
      idx_q <= 3'd0;
      cnt_q <= '0;
      pins_q <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: '0, dq_out: '0, dq_oe: 1'b0};
      rsp_valid_q <= 1'b0;
      rsp_data_q <= '0;
    end else begin
      rsp_valid_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (req_valid) begin
            cur_q <= req;
            idx_q <= 3'd0;
            state_q <= ST_NEXT;
          end
        end
        ST_NEXT: begin
          // Address and chip select settle before the strobe falls
          pins_q.addr <= step_addr;
          pins_q.ce_n <= 1'b0;
          pins_q.dq_out <= step_data;
          pins_q.dq_oe <= ~step_read;
          cnt_q <= CNT_W'(SETUP_CYC - 1);
          state_q <= ST_SETUP;
        end
        ST_SETUP: begin
          if (cnt_done) begin
            // Strobe falls after chip select so address latches here
            pins_q.we_n <= step_read;
            pins_q.oe_n <= ~step_read;
            cnt_q <= CNT_W'(PULSE_CYC + 1);
            state_q <= ST_PULSE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        ST_PULSE: begin
          if (cnt_done) begin
            // Write strobe rises first while data and chip select still hold
            pins_q.we_n <= 1'b1;
            pins_q.oe_n <= 1'b1;
            if (step_read) begin
              rsp_data_q <= dq_s2_q;
            end
            cnt_q <= CNT_W'(HOLD_CYC - 1);
            state_q <= ST_HOLD;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        ST_HOLD: begin
          if (cnt_done) begin
            pins_q.ce_n <= 1'b1;
            pins_q.dq_oe <= 1'b0;
            if (last_step) begin
              state_q <= ST_DONE;
            end else begin
              idx_q <= idx_q + 3'd1;
              state_q <= ST_NEXT;
            end
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        ST_DONE: begin
          rsp_valid_q <= 1'b1;
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Ready only while idle; response data of ID and array reads is raw device output
  logic ready_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= (state_q == ST_IDLE) && !req_valid;
    end
  end

  assign req_ready = ready_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp_data = rsp_data_q;
  assign pins = pins_q;
endmodule : flash_command_host

// File: flash_cmd_pkg.sv
// Package with command codes, addresses, bus timing and request and bus pin types
package flash_cmd_pkg;
  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] UNLOCK1_WORD = 21'h000555;
  localparam logic [ADDR_W-1:0] UNLOCK2_WORD = 21'h0002AA;
  localparam logic [ADDR_W-1:0] UNLOCK1_BYTE = 21'h000AAA;
  localparam logic [ADDR_W-1:0] UNLOCK2_BYTE = 21'h000555;
  localparam logic [ADDR_W-1:0] QUERY_WORD = 21'h000055;
  localparam logic [ADDR_W-1:0] QUERY_BYTE = 21'h0000AA;
  localparam logic [7:0] ID_OFS_MFR = 8'h00;
  localparam logic [7:0] ID_OFS_DEV1 = 8'h01;
  localparam logic [7:0] ID_OFS_DEV2 = 8'h0E;
  localparam logic [7:0] ID_OFS_DEV3 = 8'h0F;
  localparam logic [7:0] ID_OFS_LOCK = 8'h03;
  localparam logic [7:0] ID_OFS_PROT = 8'h02;
  localparam logic [7:0] CODE_UNLOCK1 = 8'hAA;
  localparam logic [7:0] CODE_UNLOCK2 = 8'h55;
  localparam logic [7:0] CODE_RESET = 8'hF0;
  localparam logic [7:0] CODE_ID = 8'h90;
  localparam logic [7:0] CODE_PROG = 8'hA0;
  localparam logic [7:0] CODE_BYPASS = 8'h20;
  localparam logic [7:0] CODE_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CODE_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CODE_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CODE_SUSPEND = 8'hB0;
  localparam logic [7:0] CODE_RESUME = 8'h30;
  localparam logic [7:0] CODE_QUERY = 8'h98;
  localparam logic [7:0] CODE_BYPASS_EXIT = 8'h00;
  localparam int BANK_LSB = 18;
  localparam int SECTOR_LSB = 12;
  // Strobe phase lengths in ns and derived cycles at 25 MHz
  localparam int CLK_NS = 40;
  localparam int SETUP_NS = 40;
  localparam int PULSE_NS = 60;
  localparam int HOLD_NS = 40;
  localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 4;

  typedef enum logic [3:0] {
    OP_ARRAY_READ = 4'h0,
    OP_RESET = 4'h1,
    OP_ID_ENTER = 4'h2,
    OP_ID_READ = 4'h3,
    OP_PROGRAM = 4'h4,
    OP_BYPASS_ENTER = 4'h5,
    OP_BYPASS_PROG = 4'h6,
    OP_BYPASS_EXIT = 4'h7,
    OP_CHIP_ERASE = 4'h8,
    OP_SECTOR_ERASE = 4'h9,
    OP_SECTOR_ADD = 4'hA,
    OP_SUSPEND = 4'hB,
    OP_RESUME = 4'hC,
    OP_QUERY = 4'hD
  } op_type;

  typedef struct packed {
    op_type op;
    logic byte_mode;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } req_type;

  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
    logic dq_oe;
  } pins_type;
endpackage : flash_cmd_pkg

// File: flash_command_host_properties.sv
// Concurrent checks on the host flash bus pins
`timescale 1ns/1ps
module flash_command_host_properties
  import flash_cmd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire req_type req,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic [DATA_W-1:0] rsp_data,
  input wire pins_type pins,
  input wire logic [DATA_W-1:0] dq_in
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_one_strobe; !(!pins.we_n && !pins.oe_n); endproperty
  property p_we_sel; !pins.we_n |-> !pins.ce_n && pins.dq_oe; endproperty
  property p_oe_sel; !pins.oe_n |-> !pins.ce_n && !pins.dq_oe; endproperty
  property p_addr_hold; !pins.we_n && !$past(pins.we_n) |-> $stable(pins.addr); endproperty
  property p_data_hold; !pins.we_n && !$past(pins.we_n) |-> $stable(pins.dq_out); endproperty
  property p_pulse; $fell(pins.we_n) |-> !pins.we_n[*2]; endproperty
  property p_setup; $fell(pins.we_n) |-> !$past(pins.ce_n); endproperty
  property p_rsp_pulse; rsp_valid |=> !rsp_valid; endproperty
  property p_busy_ready; !pins.ce_n |-> !req_ready; endproperty
  a_one_strobe: assert property (p_one_strobe)
    else $error("both strobes low");
  a_we_sel: assert property (p_we_sel)
    else $error("write without select");
  a_oe_sel: assert property (p_oe_sel)
    else $error("read while driving");
  a_addr_hold: assert property (p_addr_hold)
    else $error("address moved in write");
  a_data_hold: assert property (p_data_hold)
    else $error("data moved in write");
  a_pulse: assert property (p_pulse)
    else $error("write pulse short");
  a_setup: assert property (p_setup)
    else $error("select late");
  a_rsp_pulse: assert property (p_rsp_pulse)
    else $error("done too long");
  a_busy_ready: assert property (p_busy_ready)
    else $error("ready while bus busy");
  c_write: cover property ($fell(pins.we_n));
  c_read: cover property ($fell(pins.oe_n));
  c_done: cover property (rsp_valid);
endmodule : flash_command_host_properties

bind flash_command_host flash_command_host_properties chk (.sys_clk(sys_clk), .rst(rst),
  .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
  .rsp_data(rsp_data), .pins(pins), .dq_in(dq_in));

// File: flash_device_model.sv
// Behavioural flash device on the parallel bus
`timescale 1ns/1ps
module flash_device_model
  import flash_cmd_pkg::*;
#(
  parameter logic [15:0] MFR_CODE = 16'h00C3, // Arbitrary value
  parameter logic [15:0] DEV_CODE = 16'h2A00, // Arbitrary value
  parameter logic [15:0] LOCK_CODE = 16'h0082,
  parameter logic [15:0] PROT_CODE = 16'h0001
)
(
  input wire pins_type pins,
  output logic [DATA_W-1:0] dq_in
);
  logic id_mode = 1'h0;
  logic [7:0] prev = 8'h00;
  logic [ADDR_W-1:0] alat = '0;
  logic [ADDR_W-1:0] la = '0;
  logic [DATA_W-1:0] ld = '0;
  logic [DATA_W-1:0] last = '0;
  logic [DATA_W-1:0] rd;
  int nw = 0;
  always @(negedge pins.we_n or negedge pins.ce_n) begin
    if (!pins.we_n && !pins.ce_n) alat = pins.addr;
  end
  always @(posedge pins.we_n or posedge pins.ce_n) begin
    if (pins.we_n ^ pins.ce_n) begin
      nw++;
      la = alat;
      ld = pins.dq_out;
      if (ld[7:0] == CODE_ID && prev == CODE_UNLOCK2) id_mode = 1'h1;
      else if (ld[7:0] == CODE_RESET || ld[7:0] == CODE_BYPASS_EXIT) id_mode = 1'h0;
      prev = ld[7:0];
    end
  end
  always_comb begin
    if (!id_mode) rd = pins.addr[15:0] ^ 16'h5A5A;
    else if (pins.addr[7:0] == ID_OFS_MFR) rd = MFR_CODE;
    else if (pins.addr[7:0] == ID_OFS_LOCK) rd = LOCK_CODE;
    else if (pins.addr[7:0] == ID_OFS_PROT) rd = PROT_CODE;
    else rd = DEV_CODE | {8'h00, pins.addr[7:0]};
  end
  always @(posedge pins.oe_n) last = rd;
  assign dq_in = (!pins.ce_n && !pins.oe_n) ? rd : ~last;
endmodule : flash_device_model

// File: flash_command_host_bench.sv
// Bench driving command requests into the host against the device model
`timescale 1ns/1ps
module flash_command_host_bench;
  import flash_cmd_pkg::*;
  typedef struct packed {
    op_type op;
    logic bm;
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] d;
    logic [2:0] n;
    logic [ADDR_W-1:0] ea;
    logic [DATA_W-1:0] ed;
  } row_type;
  logic sys_clk = 1'h0;
  logic rst = 1'h1;
  logic req_valid = 1'h0;
  req_type req = '0;
  logic req_ready;
  logic rsp_valid;
  logic [DATA_W-1:0] rsp_data;
  pins_type pins;
  logic [DATA_W-1:0] dq_in;
  int bad_count = 0;
  int num_checks = 0;
  int n0;
  row_type rows [17] = '{
    '{OP_PROGRAM,1'h0,21'h012345,16'hBEEF,3'h4,21'h012345,16'hBEEF},
    '{OP_CHIP_ERASE,1'h1,21'h0,16'h0,3'h6,21'h000AAA,16'h0010},
    '{OP_SECTOR_ERASE,1'h0,21'h1F3000,16'h0,3'h6,21'h1F3000,16'h0030},
    '{OP_SECTOR_ADD,1'h0,21'h0A5000,16'h0,3'h1,21'h0A5000,16'h0030},
    '{OP_SUSPEND,1'h0,21'h140000,16'h0,3'h1,21'h140000,16'h00B0},
    '{OP_RESUME,1'h0,21'h140000,16'h0,3'h1,21'h140000,16'h0030},
    '{OP_QUERY,1'h0,21'h0,16'h0,3'h1,21'h000055,16'h0098},
    '{OP_QUERY,1'h1,21'h0,16'h0,3'h1,21'h0000AA,16'h0098},
    '{OP_BYPASS_ENTER,1'h0,21'h0,16'h0,3'h3,21'h000555,16'h0020},
    '{OP_BYPASS_PROG,1'h0,21'h0040FF,16'hA55A,3'h2,21'h0040FF,16'hA55A},
    '{OP_BYPASS_EXIT,1'h0,21'h0,16'h0,3'h2,21'h0,16'h0000},
    '{OP_ID_ENTER,1'h0,21'h0C0000,16'h0,3'h3,21'h0C0555,16'h0090},
    '{OP_ID_READ,1'h0,21'h0C000E,16'h0,3'h0,21'h0,16'h2A0E},
    '{OP_ID_READ,1'h0,21'h0C0003,16'h0,3'h0,21'h0,16'h0082},
    '{OP_ID_READ,1'h0,21'h0C3002,16'h0,3'h0,21'h0,16'h0001},
    '{OP_RESET,1'h0,21'h0,16'h0,3'h1,21'h0,16'h00F0},
    '{OP_ARRAY_READ,1'h0,21'h00ABCD,16'h0,3'h0,21'h0,16'hF197}};
  flash_command_host DUT (.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .pins(pins),
    .dq_in(dq_in));
  flash_device_model fm (.pins(pins), .dq_in(dq_in));
  always #20 sys_clk = ~sys_clk;
  task check(input string s, input logic [ADDR_W-1:0] g, input logic [ADDR_W-1:0] e);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask : check
  task tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  task run(input row_type r);
    int i;
    n0 = fm.nw;
    @(negedge sys_clk);
    req_valid = 1'h1;
    req = '{r.op, r.bm, r.a, r.d};
    for (i = 0; i < 200 && !rsp_valid; i++) begin
      @(negedge sys_clk);
      if (!pins.ce_n) req_valid = 1'h0;
    end
    check("done", rsp_valid, 1'h1);
    check("writes", ADDR_W'(fm.nw - n0), ADDR_W'(r.n));
    if (r.n != 3'h0) begin
      check("data", fm.ld, r.ed);
      if (r.ea != '0) check("addr", fm.la, r.ea);
    end else check("read", rsp_data, r.ed);
  endtask : run
  initial begin
    repeat (16) @(negedge sys_clk);
    check("ce_n in reset", pins.ce_n, 1'h1);
    rst = 1'h0;
    @(negedge sys_clk);
    check("ready after reset", req_ready, 1'h1);
    foreach (rows[k]) run(rows[k]);
    // Reset in mid-write releases the bus
    @(negedge sys_clk);
    req_valid = 1'h1;
    req = '{OP_PROGRAM, 1'h0, 21'h000010, 16'h1234};
    repeat (10) @(negedge sys_clk);
    rst = 1'h1;
    req_valid = 1'h0;
    @(negedge sys_clk);
    check("we_n after abort", pins.we_n, 1'h1);
    check("dq_oe after abort", pins.dq_oe, 1'h0);
    rst = 1'h0;
    run(rows[0]);
    tally_and_finish();
  end
  initial begin
    #200000;
    bad_count++;
    tally_and_finish();
  end
endmodule : flash_command_host_bench
